// File: src/isr_pkg.sv
`default_nettype none

package isr_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [6:0] ADDR_DEV_ID    = 7'h00;
    localparam logic [6:0] ADDR_RP_MAX    = 7'h01;
    localparam logic [6:0] ADDR_MIN_FREQ  = 7'h03;
    localparam logic [6:0] ADDR_CONV_CFG  = 7'h04;
    localparam logic [6:0] ADDR_CLK_CFG   = 7'h05;
    localparam logic [6:0] ADDR_THR_HI_L  = 7'h06;
    localparam logic [6:0] ADDR_THR_HI_H  = 7'h07;
    localparam logic [6:0] ADDR_THR_LO_L  = 7'h08;
    localparam logic [6:0] ADDR_THR_LO_H  = 7'h09;
    localparam logic [6:0] ADDR_INT_CFG   = 7'h0A;
    localparam logic [6:0] ADDR_PWR_CFG   = 7'h0B;
    localparam logic [6:0] ADDR_STATUS    = 7'h20;
    localparam logic [6:0] ADDR_PROX_L    = 7'h21;
    localparam logic [6:0] ADDR_PROX_H    = 7'h22;
    localparam logic [6:0] ADDR_FCNT_L    = 7'h23;
    localparam logic [6:0] ADDR_FCNT_M    = 7'h24;
    localparam logic [6:0] ADDR_FCNT_H    = 7'h25;
    localparam int         CFG_NUM        = 12;

    // ------------------------------------------------------------
    // Reset values of configuration registers
    // ------------------------------------------------------------
    localparam logic [7:0] RST_RP_MAX     = 8'h0E;
    localparam logic [7:0] RST_RP_MIN     = 8'h14;
    localparam logic [7:0] RST_MIN_FREQ   = 8'h45;
    localparam logic [7:0] RST_CONV_CFG   = 8'h1B;
    localparam logic [7:0] RST_CLK_CFG    = 8'h01;
    localparam logic [7:0] RST_THR_HI     = 8'hFF;
    localparam logic [7:0] RST_THR_LO     = 8'h00;
    localparam logic [7:0] RST_INT_CFG    = 8'h00;
    localparam logic [7:0] RST_PWR_CFG    = 8'h00;
    localparam logic [CFG_NUM-1:0][7:0] CFG_RESET = {
        RST_PWR_CFG, RST_INT_CFG, RST_THR_LO, RST_THR_LO, RST_THR_HI, RST_THR_HI,
        RST_CLK_CFG, RST_CONV_CFG, RST_MIN_FREQ, RST_RP_MIN, RST_RP_MAX, 8'h00};

    // ------------------------------------------------------------
    // Field positions and codes
    // ------------------------------------------------------------
    localparam int         STAT_OSC_BIT   = 7;
    localparam int         STAT_READY_BIT = 6;
    localparam int         STAT_WAKE_BIT  = 5;
    localparam int         STAT_CMP_BIT   = 4;
    localparam int         SPI_RD_BIT     = 7;
    localparam int         PWR_ACTIVE_BIT = 0;
    localparam logic [2:0] INT_MODE_WAKE  = 3'h1;
    localparam logic [2:0] RT_MIN_CODE    = 3'h2;
    localparam logic [15:0] PROX_SAT_LOW  = 16'h0000;
    localparam logic [15:0] PROX_SAT_HIGH = 16'hFFFF;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int         SYS_CLK_HZ     = 25_000_000;
    localparam int         RESP_TIME_MIN  = 192;
    localparam int         RESP_DIV       = 3;
    localparam logic [11:0] CONV_BASE_CYC = 12'(RESP_TIME_MIN / RESP_DIV);
    localparam int         WDOG_REF_HZ    = 2500;
    localparam int         WDOG_BASE_CYC  = SYS_CLK_HZ / WDOG_REF_HZ;
    localparam int         WDOG_MUL       = 3;
    localparam int         WDOG_SHR       = 6;
    localparam int         WDOG_W         = 24;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic {SPI_CMD, SPI_DATA} isr_spi_e;

    typedef struct packed {
        logic [15:0] prox;
        logic [23:0] sensor_frequency_count;
    } isr_result_s;

    typedef struct packed {
        logic [2:0]              sclk_s;
        logic [1:0]              cs_s;
        logic [1:0]              sdi_s;
        logic [2:0]              osc_s;
        logic [1:0]              under_s;
        logic [1:0]              over_s;
        logic [1:0][15:0]        rp_s;
        isr_spi_e                spi_st;
        logic [2:0]              bit_cnt;
        logic [7:0]              rx;
        logic [7:0]              tx;
        logic                    is_read;
        logic [6:0]              addr;
        logic                    sdo;
        logic [CFG_NUM-1:0][7:0] cfg;
        isr_result_s             pend;
        isr_result_s             shown;
        logic                    ready_n;
        logic                    wake_trig;
        logic                    cmp;
        logic                    osc_flag;
        logic [11:0]             osc_cnt;
        logic [23:0]             fcnt_run;
        logic [WDOG_W-1:0]       wdog;
    } isr_state_s;

endpackage

`default_nettype wire

// File: src/isr_readout.sv
`timescale 1ns/1ps
`default_nettype none

module isr_readout #(
    parameter int         WDOG_BASE_CYC_P = isr_pkg::WDOG_BASE_CYC,
    parameter logic [7:0] DEVICE_ID       = 8'h5A  // Arbitrary value
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        spi_sclk,
    input  wire logic        spi_cs_n,
    input  wire logic        spi_sdi,
    output var  logic        spi_sdo,
    input  wire logic        sensor_osc,
    input  wire logic [15:0] rp_code,
    input  wire logic        rp_under_range,
    input  wire logic        rp_over_range
);

    isr_pkg::isr_state_s q;
    isr_pkg::isr_state_s n;

    // ------------------------------------------------------------
    // Register read mux
    // ------------------------------------------------------------
    function automatic logic [7:0] rd_byte(
        input logic [6:0]                       a,
        input isr_pkg::isr_state_s              s,
        input isr_pkg::isr_result_s             r
    );
        logic [7:0] st;
        st                          = 8'h00;
        st[isr_pkg::STAT_OSC_BIT]   = s.osc_flag;
        st[isr_pkg::STAT_READY_BIT] = s.ready_n;
        st[isr_pkg::STAT_WAKE_BIT]  = (s.cfg[isr_pkg::ADDR_INT_CFG][2:0] == isr_pkg::INT_MODE_WAKE)
                                      ? ~s.wake_trig : 1'b1;
        st[isr_pkg::STAT_CMP_BIT]   = s.cmp;
        if (a == isr_pkg::ADDR_DEV_ID) begin
            rd_byte = DEVICE_ID;
        end else if (a <= isr_pkg::ADDR_PWR_CFG) begin
            rd_byte = s.cfg[a[3:0]];
        end else if (a == isr_pkg::ADDR_STATUS) begin
            rd_byte = st;
        end else if (a == isr_pkg::ADDR_PROX_L) begin
            rd_byte = r.prox[7:0];
        end else if (a == isr_pkg::ADDR_PROX_H) begin
            rd_byte = r.prox[15:8];
        end else if (a == isr_pkg::ADDR_FCNT_L) begin
            rd_byte = r.sensor_frequency_count[7:0];
        end else if (a == isr_pkg::ADDR_FCNT_M) begin
            rd_byte = r.sensor_frequency_count[15:8];
        end else if (a == isr_pkg::ADDR_FCNT_H) begin
            rd_byte = r.sensor_frequency_count[23:16];
        end else begin
            rd_byte = 8'h00;
        end
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic                  cs_act;
        logic                  sclk_rise;
        logic                  sclk_fall;
        logic                  osc_rise;
        logic                  active;
        logic                  capture;
        logic                  conv_done;
        logic [7:0]            rx_nxt;
        logic [6:0]            rd_addr;
        logic [15:0]           prox_sat;
        logic [15:0]           thr_hi;
        logic [15:0]           thr_lo;
        logic [2:0]            rt;
        logic [11:0]           conv_len;
        logic [9:0]            m_scaled;
        logic [3:0]            wdog_shift;
        logic [isr_pkg::WDOG_W-1:0] wdog_win;
        isr_pkg::isr_result_s  rd_src;

        n          = q;
        cs_act     = 1'b0;
        capture    = 1'b0;
        conv_done  = 1'b0;
        rd_addr    = q.addr;
        prox_sat   = q.rp_s[1];
        rd_src     = q.shown;

        // Synchronisers
        n.sclk_s   = {q.sclk_s[1:0], spi_sclk};
        n.cs_s     = {q.cs_s[0], spi_cs_n};
        n.sdi_s    = {q.sdi_s[0], spi_sdi};
        n.osc_s    = {q.osc_s[1:0], sensor_osc};
        n.under_s  = {q.under_s[0], rp_under_range};
        n.over_s   = {q.over_s[0], rp_over_range};
        n.rp_s     = {q.rp_s[0], rp_code};
        cs_act     = ~q.cs_s[1];
        sclk_rise  = q.sclk_s[1] & ~q.sclk_s[2];
        sclk_fall  = ~q.sclk_s[1] & q.sclk_s[2];
        osc_rise   = q.osc_s[1] & ~q.osc_s[2];
        rx_nxt     = {q.rx[6:0], q.sdi_s[1]};
        active     = q.cfg[isr_pkg::ADDR_PWR_CFG][isr_pkg::PWR_ACTIVE_BIT];
        thr_hi     = {q.cfg[isr_pkg::ADDR_THR_HI_H], q.cfg[isr_pkg::ADDR_THR_HI_L]};
        thr_lo     = {q.cfg[isr_pkg::ADDR_THR_LO_H], q.cfg[isr_pkg::ADDR_THR_LO_L]};

        // ------------------------------------------------------------
        // Conversion timing and result
        // ------------------------------------------------------------
        rt         = q.cfg[isr_pkg::ADDR_CONV_CFG][2:0];
        conv_len   = (rt < isr_pkg::RT_MIN_CODE) ? isr_pkg::CONV_BASE_CYC
                   : 12'(isr_pkg::CONV_BASE_CYC << (rt - isr_pkg::RT_MIN_CODE));
        m_scaled   = 10'(q.cfg[isr_pkg::ADDR_MIN_FREQ] * isr_pkg::WDOG_MUL);
        wdog_shift = 4'(m_scaled >> isr_pkg::WDOG_SHR);
        wdog_win   = isr_pkg::WDOG_W'(WDOG_BASE_CYC_P) >> wdog_shift;
        if (q.under_s[1]) begin
            prox_sat = isr_pkg::PROX_SAT_LOW;
        end else if (q.over_s[1]) begin
            prox_sat = isr_pkg::PROX_SAT_HIGH;
        end

        if (!active) begin
            n.osc_cnt  = 12'h000;
            n.fcnt_run = 24'h000000;
            n.wdog     = '0;
            n.osc_flag = 1'b0;
        end else begin
            if (q.fcnt_run != 24'hFFFFFF) begin
                n.fcnt_run = q.fcnt_run + 24'h000001;
            end
            if (osc_rise) begin
                n.wdog     = '0;
                n.osc_flag = 1'b0;
                n.osc_cnt  = q.osc_cnt + 12'h001;
                if (q.osc_cnt + 12'h001 >= conv_len) begin
                    conv_done        = 1'b1;
                    n.osc_cnt        = 12'h000;
                    n.fcnt_run       = 24'h000001;
                    n.pend.prox      = prox_sat;
                    n.pend.sensor_frequency_count    = q.fcnt_run;
                    n.wake_trig      = (prox_sat > thr_hi);
                    if (prox_sat < thr_lo) begin
                        n.cmp = 1'b1;
                    end else if (prox_sat > thr_hi) begin
                        n.cmp = 1'b0;
                    end
                end
            end else if (q.wdog >= wdog_win) begin
                n.osc_flag = 1'b1;
            end else begin
                n.wdog = q.wdog + isr_pkg::WDOG_W'(1);
            end
        end

        // ------------------------------------------------------------
        // Serial slave
        // ------------------------------------------------------------
        if (!cs_act) begin
            n.spi_st  = isr_pkg::SPI_CMD;
            n.bit_cnt = 3'h0;
            n.sdo     = 1'b0;
            n.tx      = 8'h00;
        end else begin
            if (sclk_rise) begin
                n.rx      = rx_nxt;
                n.bit_cnt = q.bit_cnt + 3'h1;
                if (q.bit_cnt == 3'h7) begin
                    case (q.spi_st)
                        isr_pkg::SPI_CMD: begin
                            n.is_read = rx_nxt[isr_pkg::SPI_RD_BIT];
                            n.addr    = rx_nxt[6:0];
                            n.spi_st  = isr_pkg::SPI_DATA;
                            rd_addr   = rx_nxt[6:0];
                            capture   = rx_nxt[isr_pkg::SPI_RD_BIT]
                                        && (rx_nxt[6:0] == isr_pkg::ADDR_PROX_L);
                        end
                        default: begin
                            if (!q.is_read && q.addr != isr_pkg::ADDR_DEV_ID
                                && q.addr <= isr_pkg::ADDR_PWR_CFG
                                && !(active && q.addr >= isr_pkg::ADDR_RP_MAX
                                     && q.addr <= isr_pkg::ADDR_CLK_CFG)) begin
                                n.cfg[q.addr[3:0]] = rx_nxt;
                            end
                            n.addr  = q.addr + 7'h01;
                            rd_addr = q.addr + 7'h01;
                        end
                    endcase
                    rd_src = capture ? q.pend : q.shown;
                    n.tx   = rd_byte(rd_addr, q, rd_src);
                end
            end
            if (sclk_fall) begin
                n.sdo = q.tx[7];
                n.tx  = {q.tx[6:0], 1'b0};
            end
        end

        if (capture) begin
            n.shown  = q.pend;
            n.ready_n = 1'b1;
        end
        if (conv_done) begin
            n.ready_n = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q        <= '0;
            q.cs_s   <= 2'h3;
            q.cfg    <= isr_pkg::CFG_RESET;
            q.ready_n <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign spi_sdo = q.sdo;

endmodule

`default_nettype wire

// File: test/isr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module isr_host_model (
    output logic     spi_sclk,
    output logic     spi_cs_n,
    output logic     spi_sdi,
    input wire logic spi_sdo
);
    // ------------------------------------------------------------
    // Serial master: mode 0, clock stands low between frames
    // ------------------------------------------------------------
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_sdi  = 1'b0;
    end
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, input int n, output logic [47:0] rd);
        logic [7:0] b;
        rd = '0;
        #40 spi_cs_n = 1'b0;
        for (int i = 0; i <= n; i++) begin
            b = (i == 0) ? cmd : wd;
            for (int k = 7; k >= 0; k--) begin
                spi_sdi = b[k];
                #160 spi_sclk = 1'b1;
                if (i > 0) rd = {rd[46:0], spi_sdo};
                #160 spi_sclk = 1'b0;
            end
        end
        #160 spi_cs_n = 1'b1;
        spi_sdi = ~spi_sdi;
        #200;
    endtask
endmodule
`default_nettype wire

// File: test/isr_readout_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module isr_readout_assertions #(
    parameter int WDOG_BASE_CYC_P = 10000
) (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        spi_sclk,
    input wire logic        spi_cs_n,
    input wire logic        spi_sdi,
    input wire logic        spi_sdo,
    input wire logic        sensor_osc,
    input wire logic [15:0] rp_code,
    input wire logic        rp_under_range,
    input wire logic        rp_over_range
);
    // ------------------------------------------------------------
    // Frame decode
    // ------------------------------------------------------------
    logic        sclk_ff;
    logic        osc_ff;
    logic        act_ff;
    logic        wake_ff;
    logic [5:0]  rcnt_ff;
    logic [6:0]  dsh_ff;
    logic [7:0]  cmd_ff;
    logic [15:0] idle_ff;
    logic [15:0] gmax_ff;
    logic        rise;
    logic        stat;
    assign rise = spi_sclk && !sclk_ff && !spi_cs_n;
    assign stat = rise && cmd_ff == 8'hA0;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_ff <= 1'b0;
            osc_ff  <= 1'b0;
            act_ff  <= 1'b0;
            wake_ff <= 1'b0;
            rcnt_ff <= 6'h00;
            dsh_ff  <= 7'h00;
            cmd_ff  <= 8'h00;
            idle_ff <= 16'h0000;
            gmax_ff <= 16'h0000;
        end else begin
            sclk_ff <= spi_sclk;
            osc_ff  <= sensor_osc;
            idle_ff <= (sensor_osc && !osc_ff) ? 16'h0000 : idle_ff + {15'h0000, ~&idle_ff};
            gmax_ff <= (spi_cs_n || idle_ff > gmax_ff) ? idle_ff : gmax_ff;
            rcnt_ff <= spi_cs_n ? 6'h00 : rcnt_ff + {5'h00, rise};
            if (rise) begin
                dsh_ff <= {dsh_ff[5:0], spi_sdi};
            end
            if (rise && rcnt_ff == 6'h07) begin
                cmd_ff <= {dsh_ff, spi_sdi};
            end
            if (rise && rcnt_ff == 6'h0F && cmd_ff == 8'h0B) begin
                act_ff <= spi_sdi;
            end
            if (rise && rcnt_ff == 6'h0F && cmd_ff == 8'h0A) begin
                wake_ff <= {dsh_ff[1:0], spi_sdi} == 3'h1;
            end
        end
    end
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_sdo_idle_low: assert property (spi_cs_n [*4] |-> !spi_sdo)
        else $error("serial output not low while deselected");
    a_sdo_steady_high: assert property (spi_sclk [*4] |-> $stable(spi_sdo))
        else $error("serial output moved while clock high");
    a_cmd_byte_quiet: assert property (!spi_cs_n && rcnt_ff < 6'h08 |-> !spi_sdo)
        else $error("serial output active during command byte");
    a_unmapped_zero: assert property (rise && cmd_ff[7] && cmd_ff[6:4] == 3'h3 |-> !spi_sdo)
        else $error("unmapped read not zero");
    a_stat_low_zero: assert property (stat && rcnt_ff >= 6'h0C && rcnt_ff <= 6'h0F |-> !spi_sdo)
        else $error("status low nibble not zero");
    a_osc_flag_set: assert property (stat && rcnt_ff == 6'h08 && act_ff && idle_ff >= WDOG_BASE_CYC_P + 16 |-> spi_sdo)
        else $error("oscillation timeout flag missing");
    a_osc_flag_clear: assert property (stat && rcnt_ff == 6'h08 && gmax_ff < 16'h001E |-> !spi_sdo)
        else $error("oscillation timeout flag with sensor running");
    a_wake_off_one: assert property (stat && rcnt_ff == 6'h0A && !wake_ff |-> spi_sdo)
        else $error("wake bit low while wake disabled");
    c_stat_read: cover property (stat && rcnt_ff == 6'h08);
    c_burst_end: cover property (rise && cmd_ff == 8'hA1 && rcnt_ff == 6'h2F);
    c_osc_dead: cover property (act_ff && idle_ff >= 16'(WDOG_BASE_CYC_P));
endmodule
bind isr_readout isr_readout_assertions #(.WDOG_BASE_CYC_P(WDOG_BASE_CYC_P)) u_chk (.sys_clk, .rst_n,
    .spi_sclk, .spi_cs_n, .spi_sdi, .spi_sdo, .sensor_osc, .rp_code, .rp_under_range, .rp_over_range);
`default_nettype wire

// File: test/isr_readout_tb.sv
`timescale 1ns/1ps
`default_nettype none
module isr_readout_tb;
    localparam int          WDOG = 400;
    localparam logic [23:0] FCNT = 24'((64 << (7 - 2)) * 4);
    logic        sys_clk;
    logic        rst_n;
    logic        spi_sclk;
    logic        spi_cs_n;
    logic        spi_sdi;
    logic        spi_sdo;
    logic        sensor_osc = 1'b0;
    logic        osc_run;
    logic        osc_ph = 1'b0;
    logic        rp_under_range;
    logic        rp_over_range;
    logic [15:0] rp_code;
    logic [15:0] prev;
    logic [47:0] r;
    logic [14:0] cfg [9] = '{15'h0112, 15'h023B, 15'h041F, 15'h0600, 15'h0780, 15'h0800, 15'h0940, 15'h0A01,
                             15'h0B01};
    int          miscompares;
    int          n_compared;
    isr_readout #(.WDOG_BASE_CYC_P(WDOG)) dut (.sys_clk, .rst_n, .spi_sclk, .spi_cs_n, .spi_sdi, .spi_sdo,
        .sensor_osc, .rp_code, .rp_under_range, .rp_over_range);
    isr_host_model host (.spi_sclk, .spi_cs_n, .spi_sdi, .spi_sdo);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic close_out;
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic xf(input logic [7:0] c, input logic [7:0] d, input int n);
        host.xfer(c, d, n, r);
    endtask
    task automatic idle(input int n, input logic run);
        @(negedge sys_clk);
        osc_run = run;
        repeat (n) @(negedge sys_clk);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        xf(8'hA0, 8'h00, 1);
        check(24'(r[7:0] & 8'hEF), 24'h000060);
        xf(8'hA1, 8'h00, 5);
        check(r[39:16], 24'h000000);
        xf(8'hB0, 8'h00, 2);
        check(24'(r[15:0]), 24'h000000);
        foreach (cfg[i]) xf({1'b0, cfg[i][14:8]}, cfg[i][7:0], 1);
    endtask
    task automatic t_conv(input logic u, input logic o, input logic [15:0] c, input logic [15:0] p,
                          input logic [1:0] st);
        @(negedge sys_clk);
        rp_under_range = u;
        rp_over_range = o;
        rp_code = c;
        idle(16600, 1'b1);
        idle(1, 1'b0);
        xf(8'h22, 8'h77, 1);
        xf(8'hA2, 8'h00, 1);
        check(24'(r[7:0]), 24'(prev[15:8]));
        xf(8'hA0, 8'h00, 1);
        check(24'(r[6:4]), 24'({1'b0, st}));
        xf(8'hA1, 8'h00, 5);
        check(24'({r[31:24], r[39:32]}), 24'(p));
        check({r[7:0], r[15:8], r[23:16]}, FCNT);
        xf(8'hA0, 8'h00, 1);
        check(24'(r[6]), 24'h000001);
        prev = p;
    endtask
    task automatic t_wdog;
        idle(100, 1'b0);
        xf(8'hA0, 8'h00, 1);
        check(24'(r[7]), 24'h000001);
        idle(20, 1'b1);
        xf(8'hA0, 8'h00, 1);
        check(24'(r[7]), 24'h000000);
        xf(8'h0B, 8'h00, 1);
        xf(8'h03, 8'h00, 1);
        xf(8'h0B, 8'h01, 1);
        xf(8'h03, 8'h45, 1);
        xf(8'h83, 8'h00, 1);
        check(24'(r[7:0]), 24'h000000);
        idle(100, 1'b0);
        xf(8'hA0, 8'h00, 1);
        check(24'(r[7]), 24'h000000);
        idle(400, 1'b0);
        xf(8'hA0, 8'h00, 1);
        check(24'(r[7]), 24'h000001);
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    always @(negedge sys_clk) begin
        if (osc_run) begin
            osc_ph <= ~osc_ph;
            if (osc_ph) sensor_osc <= ~sensor_osc;
        end
    end
    initial begin
        rst_n = 1'b0;
        osc_run = 1'b1;
        rp_under_range = 1'b0;
        rp_over_range = 1'b0;
        rp_code = 16'h0000;
        prev = 16'h0000;
        miscompares = 0;
        n_compared = 0;
        repeat (8) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        t_reset;
        t_conv(1'b0, 1'b0, 16'hA55A, 16'hA55A, 2'b00);
        t_conv(1'b1, 1'b0, 16'hA55A, 16'h0000, 2'b11);
        t_conv(1'b0, 1'b1, 16'h0123, 16'hFFFF, 2'b00);
        t_wdog;
        close_out;
    end
    initial begin
        repeat (90000) @(posedge sys_clk);
        miscompares++;
        close_out;
    end
endmodule
`default_nettype wire
